// ==== hw/cim_pkg.sv ====
package cim_pkg;

    // clock interrupt mask register, field positions
    localparam int unsigned REG_W          = 8;
    localparam int unsigned BIT_STOP_DLY   = 7;
    localparam int unsigned BIT_IRQ_DLY_EN = 6;
    localparam int unsigned BIT_EVENT_EN   = 5;
    localparam int unsigned BIT_ALARM_EN   = 4;
    localparam int unsigned BIT_TIMER_EN   = 3;
    localparam int unsigned RSVD_HI        = 2;
    localparam int unsigned RSVD_LO        = 0;

    // all enables default to disabled, short stop delay
    localparam logic [7:0] REG_RESET = 8'h00;

    // countdown source rate selection that never gets the irq delay
    localparam logic [1:0] RATE_4096HZ = 2'h0;

    // interrupt sources in the per-source loop
    localparam int unsigned SRC_N     = 3;
    localparam int unsigned SRC_EVENT = 0;
    localparam int unsigned SRC_ALARM = 1;
    localparam int unsigned SRC_TIMER = 2;

    // timing
    localparam longint unsigned CLK_HZ            = 50_000_000;
    localparam longint unsigned STOP_OFF_SHORT_US = 1_400;
    localparam longint unsigned STOP_OFF_LONG_US  = 75_000;
    localparam longint unsigned IRQ_HOLD_DIV      = 256;

    localparam int unsigned CNT_W = 22;

    // typical figures, rounded down
    localparam longint unsigned STOP_OFF_SHORT_CYC = CLK_HZ / 1_000_000 * STOP_OFF_SHORT_US;
    localparam longint unsigned STOP_OFF_LONG_CYC  = CLK_HZ / 1_000_000 * STOP_OFF_LONG_US;
    // least hold time, rounded up
    localparam longint unsigned IRQ_HOLD_CYC = (CLK_HZ + IRQ_HOLD_DIV - 1) / IRQ_HOLD_DIV;

endpackage

// ==== hw/cim_interval_timer.sv ====
`timescale 1ns/10ps

module cim_interval_timer #(
    parameter int unsigned CNT_W = 22
) (
    input  wire logic             mclk_in,
    input  wire logic             rst_n_in,
    input  wire logic             start_in,
    input  wire logic [CNT_W-1:0] load_in,
    output logic                  busy_out
);

    logic [CNT_W-1:0] count_r;

    // a new start restarts the interval from its full length
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            count_r <= '0;
        end else if (start_in) begin
            count_r <= load_in;
        end else if (count_r != '0) begin
            count_r <= count_r - 1'b1;
        end
    end

    assign busy_out = (count_r != '0);

endmodule

// ==== hw/cim_clock_irq_mask.sv ====
`timescale 1ns/10ps

module cim_clock_irq_mask #(
    parameter int unsigned CNT_W          = cim_pkg::CNT_W,
    parameter int unsigned STOP_SHORT_CYC = int'(cim_pkg::STOP_OFF_SHORT_CYC),
    parameter int unsigned STOP_LONG_CYC  = int'(cim_pkg::STOP_OFF_LONG_CYC),
    parameter int unsigned IRQ_HOLD_CYC   = int'(cim_pkg::IRQ_HOLD_CYC)
) (
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    input  wire logic        reg_wr_in,
    input  wire logic [7:0]  reg_wdata_in,
    output logic      [7:0]  reg_rdata_out,
    input  wire logic        i2c_stop_in,
    input  wire logic        clock_off_delay_enable_in,
    input  wire logic        direct_clock_out_disable_in,
    input  wire logic [1:0]  timer_source_rate_select_in,
    input  wire logic        event_input_irq_signal_in,
    input  wire logic        alarm_irq_signal_in,
    input  wire logic        countdown_irq_signal_in,
    output logic             clock_output_pin_en_out,
    output logic             irq_out
);

    localparam logic [CNT_W-1:0] STOP_SHORT_LD = CNT_W'(STOP_SHORT_CYC);
    localparam logic [CNT_W-1:0] STOP_LONG_LD  = CNT_W'(STOP_LONG_CYC);
    localparam logic [CNT_W-1:0] IRQ_HOLD_LD   = CNT_W'(IRQ_HOLD_CYC);

    logic [7:0]               mask_r;
    logic                     clk_on_r;
    logic                     clk_on_nxt;
    logic                     irq_r;
    logic                     irq_nxt;

    localparam int unsigned SRC_BITS = cim_pkg::SRC_N;

    logic                     stop_off_delay_select;
    logic                     irq_after_clock_on_delay_en;
    logic [SRC_BITS-1:0]      src_clk_en;
    logic [SRC_BITS-1:0]      src_irq;
    logic [SRC_BITS-1:0]      src_delayable;
    logic [SRC_BITS-1:0]      src_sel;
    logic [SRC_BITS-1:0]      src_pass;

    logic                     stop_start;
    logic [CNT_W-1:0]         stop_load;
    logic                     stop_busy;
    logic                     hold_start;
    logic                     hold_busy;
    logic                     hold_active;
    logic                     any_sel;

    // register: written whole by the I2C byte engine, read back as stored
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            mask_r <= cim_pkg::REG_RESET;
        end else if (reg_wr_in) begin
            mask_r <= reg_wdata_in;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= cim_pkg::REG_RESET;
        end else if (reg_wr_in) begin
            reg_rdata_out <= reg_wdata_in;
        end
    end

    assign stop_off_delay_select       = mask_r[cim_pkg::BIT_STOP_DLY];
    assign irq_after_clock_on_delay_en = mask_r[cim_pkg::BIT_IRQ_DLY_EN];

    assign src_clk_en[cim_pkg::SRC_EVENT] = mask_r[cim_pkg::BIT_EVENT_EN];
    assign src_clk_en[cim_pkg::SRC_ALARM] = mask_r[cim_pkg::BIT_ALARM_EN];
    assign src_clk_en[cim_pkg::SRC_TIMER] = mask_r[cim_pkg::BIT_TIMER_EN];

    assign src_irq[cim_pkg::SRC_EVENT] = event_input_irq_signal_in;
    assign src_irq[cim_pkg::SRC_ALARM] = alarm_irq_signal_in;
    assign src_irq[cim_pkg::SRC_TIMER] = countdown_irq_signal_in;

    // at 4096 Hz the countdown event is too fast to hold back
    assign src_delayable[cim_pkg::SRC_EVENT] = 1'b1;
    assign src_delayable[cim_pkg::SRC_ALARM] = 1'b1;
    assign src_delayable[cim_pkg::SRC_TIMER] =
        (timer_source_rate_select_in != cim_pkg::RATE_4096HZ);

    // delay only counts while clock-on is interrupt driven
    assign hold_active = irq_after_clock_on_delay_en
                       & direct_clock_out_disable_in
                       & (hold_start | hold_busy);

    genvar g;
    generate
        for (g = 0; g < SRC_BITS; g++) begin : g_src
            // enabled source asks for the clock output
            assign src_sel[g] = src_irq[g] & src_clk_en[g];
            // enabled, delayable sources are held back; others pass straight
            assign src_pass[g] = src_irq[g]
                               & ~(src_clk_en[g] & src_delayable[g] & hold_active);
        end
    endgenerate

    assign any_sel = |src_sel;

    // stop-off hold: only when the event control enables it
    assign stop_start = i2c_stop_in & clock_off_delay_enable_in;
    assign stop_load  = stop_off_delay_select ? STOP_LONG_LD : STOP_SHORT_LD;

    cim_interval_timer #(
        .CNT_W    (CNT_W)
    ) u_stop_timer (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .start_in (stop_start),
        .load_in  (stop_load),
        .busy_out (stop_busy)
    );

    // clock output: directly enabled, interrupt driven, or held after STOP
    always_comb begin
        clk_on_nxt = ~direct_clock_out_disable_in
                   | any_sel
                   | stop_start
                   | stop_busy;
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            clk_on_r <= 1'b0;
        end else begin
            clk_on_r <= clk_on_nxt;
        end
    end

    assign clock_output_pin_en_out = clk_on_r;

    // hold window opens on the clock output's off-to-on edge
    assign hold_start = clk_on_nxt & ~clk_on_r;

    cim_interval_timer #(
        .CNT_W    (CNT_W)
    ) u_hold_timer (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .start_in (hold_start),
        .load_in  (IRQ_HOLD_LD),
        .busy_out (hold_busy)
    );

    // interrupt output: level, follows the sources one cycle late
    always_comb begin
        irq_nxt = |src_pass;
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    assign irq_out = irq_r;

endmodule

// ==== dv/cim_host_model.sv ====
`timescale 1ns/10ps
module cim_host_model (
    input  wire logic       mclk_in,
    output logic            reg_wr_out,
    output logic      [7:0] reg_wdata_out,
    output logic            i2c_stop_out
);
    initial begin
        reg_wr_out = 1'b0;
        reg_wdata_out = 8'h00;
        i2c_stop_out = 1'b0;
    end
    // released byte is inverted so a stale value never looks valid
    task automatic put(input logic [7:0] d, input logic s);
        @(posedge mclk_in);
        reg_wr_out <= !s;
        reg_wdata_out <= d;
        i2c_stop_out <= s;
        @(posedge mclk_in);
        reg_wr_out <= 1'b0;
        i2c_stop_out <= 1'b0;
        reg_wdata_out <= ~d;
    endtask
endmodule

// ==== dv/cim_clock_irq_mask_sva.sv ====
`timescale 1ns/10ps
module cim_mask_chk #(
    parameter int unsigned IRQ_HOLD_CYC = 10
) (
    input wire logic       mclk_in,
    input wire logic       rst_n_in,
    input wire logic       reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       i2c_stop_in,
    input wire logic       clock_off_delay_enable_in,
    input wire logic       direct_clock_out_disable_in,
    input wire logic [1:0] timer_source_rate_select_in,
    input wire logic       event_input_irq_signal_in,
    input wire logic       alarm_irq_signal_in,
    input wire logic       countdown_irq_signal_in,
    input wire logic       clock_output_pin_en_out,
    input wire logic       irq_out
);
    localparam int HOLD_MAX = IRQ_HOLD_CYC + 4;
    wire       ev = event_input_irq_signal_in;
    wire       al = alarm_irq_signal_in;
    wire       tm = countdown_irq_signal_in;
    wire       ce = clock_output_pin_en_out;
    wire       dis = direct_clock_out_disable_in;
    wire [7:0] m = reg_rdata_out;
    wire       hs = m[6] & dis & m[5] & ev & ~al & ~tm;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    sequence held_s;
        !irq_out [*8];
    endsequence
    sequence late_s;
        ##[0:HOLD_MAX] irq_out;
    endsequence
    event_on_a: assert property (ev && m[5] |=> ce)
        else $error("event did not enable clock");
    alarm_on_a: assert property (al && m[4] |=> ce)
        else $error("alarm did not enable clock");
    timer_on_a: assert property (tm && m[3] |=> ce)
        else $error("timer did not enable clock");
    no_delay_a: assert property ((ev | al | tm) && !m[6] |=> irq_out)
        else $error("irq delayed while delay off");
    direct_irq_a: assert property (!dis && (ev | al | tm) |=> irq_out)
        else $error("irq delayed while direct clock on");
    unsel_irq_a: assert property (ev && !m[5] |=> irq_out)
        else $error("unselected source delayed");
    fast_timer_a: assert property (tm && timer_source_rate_select_in == 2'h0 |=> irq_out)
        else $error("fast timer irq delayed");
    hold_a: assert property ($rose(ce) && hs |-> held_s ##1 late_s)
        else $error("irq hold after clock on wrong");
    stop_win_a: assert property (i2c_stop_in && clock_off_delay_enable_in |=> ce [*8])
        else $error("clock off too soon after stop");
endmodule
bind cim_clock_irq_mask cim_mask_chk #(.IRQ_HOLD_CYC(IRQ_HOLD_CYC)) u_chk (.mclk_in(mclk_in),
    .rst_n_in(rst_n_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .i2c_stop_in(i2c_stop_in),
    .clock_off_delay_enable_in(clock_off_delay_enable_in),
    .direct_clock_out_disable_in(direct_clock_out_disable_in),
    .timer_source_rate_select_in(timer_source_rate_select_in),
    .event_input_irq_signal_in(event_input_irq_signal_in),
    .alarm_irq_signal_in(alarm_irq_signal_in), .countdown_irq_signal_in(countdown_irq_signal_in),
    .clock_output_pin_en_out(clock_output_pin_en_out), .irq_out(irq_out));

// ==== dv/cim_clock_irq_mask_tb_top.sv ====
`timescale 1ns/10ps
module cim_clock_irq_mask_tb_top;
    localparam int SHORT = 20;
    localparam int LONG  = 50;
    localparam int HOLD  = 10;
    logic        mclk_in, rst_n_in, wr, stp, cde, dis, ev, al, tm, ce, irq;
    logic [7:0]  wd, rd;
    logic [1:0]  rate;
    int          bad_count, comparisons, n, e;
    int unsigned seed;
    logic [7:0]  exp_q[$];
    cim_host_model u_cim_host_model (.mclk_in(mclk_in), .reg_wr_out(wr), .reg_wdata_out(wd),
        .i2c_stop_out(stp));
    cim_clock_irq_mask #(.STOP_SHORT_CYC(SHORT), .STOP_LONG_CYC(LONG), .IRQ_HOLD_CYC(HOLD))
        u_cim_clock_irq_mask (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_wr_in(wr),
        .reg_wdata_in(wd), .reg_rdata_out(rd), .i2c_stop_in(stp),
        .clock_off_delay_enable_in(cde), .direct_clock_out_disable_in(dis),
        .timer_source_rate_select_in(rate), .event_input_irq_signal_in(ev),
        .alarm_irq_signal_in(al), .countdown_irq_signal_in(tm),
        .clock_output_pin_en_out(ce), .irq_out(irq));
    function automatic int unsigned xs(input int unsigned v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic check(input string w, input logic [7:0] x, input logic [7:0] g);
        comparisons++;
        if (g !== x) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", w, x, g);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge mclk_in);
        #1;
    endtask
    task automatic put(input logic [7:0] d, input logic s);
        u_cim_host_model.put(d, s);
        #1;
    endtask
    task automatic src(input logic [2:0] v, input logic [1:0] r);
        @(posedge mclk_in);
        {ev, al, tm} <= v;
        rate <= r;
        #1;
    endtask
    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end
    initial begin
        repeat (3000) @(posedge mclk_in);
        bad_count++;
        final_report();
    end
    initial begin
        {rst_n_in, cde, dis, ev, al, tm, rate} = '0;
        seed = 32'h7e396e7f;
        repeat (6) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        #1;
        check("mask", 8'h00, rd);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            exp_q.push_back(seed[7:0]);
            put(seed[7:0], 1'b0);
            check("mask", exp_q.pop_front(), rd);
        end
        $display("readback done");
        @(posedge mclk_in);
        dis <= 1'b1;
        for (int s = 0; s < 6; s++) begin
            put(s[0] ? 8'h20 >> (s / 2) : 8'h00, 1'b0);
            src(3'b100 >> (s / 2), 2'h1);
            step(1);
            check("clock out", 8'(s[0]), 8'(ce));
            check("irq", 8'h01, 8'(irq));
            src(3'b000, 2'h1);
            step(2);
            check("clock out", 8'h00, 8'(ce));
        end
        $display("source select done");
        // event and slower-rate timer are held back after clock on; timer at the fastest rate must never be held back
        for (int k = 0; k < 3; k++) begin
            put(k == 0 ? 8'h60 : 8'h48, 1'b0);
            src(k == 0 ? 3'b100 : 3'b001, k == 2 ? 2'h0 : 2'h1);
            for (n = 0; irq !== 1'b1 && n < 100; n++) step(1);
            check("irq delay ok", 8'h01, 8'(k == 2 ? n == 1 : n >= HOLD && n <= HOLD * 3 / 2 + 3));
            src(3'b000, 2'h1);
            step(4);
        end
        $display("irq delay done");
        for (int k = 0; k < 3; k++) begin
            @(posedge mclk_in);
            cde <= (k != 2);
            put(k == 0 ? 8'h00 : 8'h80, 1'b0);
            put(8'h00, 1'b1);
            e = k == 2 ? 0 : (k == 1 ? LONG + 1 : SHORT + 1);
            n = 0;
            repeat (LONG + 10) begin
                step(1);
                n += int'(ce);
            end
            check("stop window ok", 8'h01, 8'(n >= e - 1 && n <= e + 1 && (e > 0 || n == 0)));
        end
        $display("stop window done");
        final_report();
    end
endmodule
